// File: logic/cam_seq_params.svh
// Timing, geometry and field constants of the acquisition sequencer
`ifndef CAM_SEQ_PARAMS_SVH
`define CAM_SEQ_PARAMS_SVH
`define ROW_CLOCKS        12'd2624
`define FULL_FRAME_ROWS   16'd1080
`define SHORT_TOP_ROWS    32'd3
`define LONG_MIN_ROWS     32'd4
`define MIN_PULSE_CLKS    32'd2
`define MEM_DEPTH         4
`define MEM_PTR_W         2
`define FRAME_ID_W        8
`endif

// File: logic/cam_seq_pkg.sv
// Types shared by the acquisition sequencer
package cam_seq_pkg;
  typedef enum logic [2:0] {
    TRIG_INT, TRIG_INT_OVL, TRIG_EXT, TRIG_EXT_OVL,
    TRIG_EXPO, TRIG_EXPO_OVL, TRIG_START, TRIG_START_OVL
  } trig_mode_type;
  typedef enum logic [1:0] {ACQ_SINGLE, ACQ_SERIES, ACQ_CONT} acq_mode_type;
endpackage : cam_seq_pkg

// File: logic/camera_acquisition_sequencer.sv
// Global-shutter trigger, exposure and frame sequencer with frame memory
`timescale 1ns/100ps
`include "cam_seq_params.svh"

// Functional notes
// - Exposure rounded up to whole rows.
// - Row period is 2624 readout clocks.
// - Frame rows from readout window height.
// - Short/long class locked while acquiring.
// - Internal non-overlap short/long exposure ranges.
// - Overlap minimum frame plus gap plus row.
// - External trigger sets cycle, pulse width unchecked.
// - Pulse width sets exposure, min enforced.
// - Edge interval sets exposure, min twice frame plus gap.
// - External start then runs like internal.
// - Reference plus image form one frame.
// - Triggers only accepted while ready.
// - Single scan takes exactly one frame.
// - Series stops at programmed frame count.
// - Frames stored then sent in order.
// - Full memory stalls triggered series; internal timing drops frames.
// - Internally timed continuous aborts when a frame finds memory full.
// - New exposure applies from next frame.
// - Mid-run exposure clamped to mode range.
// - Internal rate set only before start.
// - Ready output marks accepted rising edges.
// - First overlap exposure frame discarded.
module camera_acquisition_sequencer
  import cam_seq_pkg::*;
(
  input  wire logic                       clk,            // 100 MHz readout clock
  input  wire logic                       rst_n,          // Async reset, active low
  input  wire cam_seq_pkg::trig_mode_type trigMode,       // Triggering mode
  input  wire cam_seq_pkg::acq_mode_type  acqMode,        // Acquisition mode
  input  wire logic                       acqStart,       // Start acquisition pulse
  input  wire logic                       acqAbort,       // Abort pulse
  input  wire logic [15:0]                windowRows,     // Readout window rows per frame, 0 = 1080
  input  wire logic [15:0]                interFrameRows, // Inter-frame gap in rows
  input  wire logic [31:0]                exposureClks,   // Requested exposure, clocks
  input  wire logic                       exposureWr,     // Exposure write strobe
  input  wire logic [31:0]                cyclePeriodRows,// Internal cycle, 0 = fastest
  input  wire logic [31:0]                frameCount,     // Series length
  input  wire logic                       extTrigger,     // External trigger input
  input  wire logic                       hostTrigger,    // host_issued_trigger pulse
  input  wire logic                       txReady,        // Host link can take a frame
  output logic                            triggerReady,   // Ready for rising edge
  output logic                            acquiring,      // Acquisition running
  output logic                            exposing,       // Sensor exposing
  output logic                            frameValid,     // Frame leaves to host
  output logic [7:0]                      frameId,        // Id of outgoing frame
  output logic                            memFull,        // Frame memory full
  output logic                            acqAborted,     // Ended by overflow
  output logic [31:0]                     exposureRows_q  // Active exposure, rows
);
  import cam_seq_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_ARMED, S_EXPOSE, S_READ, S_WAIT} state_type;

  function automatic logic [31:0] clks_to_rows(input logic [31:0] c);
    clks_to_rows = (c + 32'(`ROW_CLOCKS) - 32'd1) / 32'(`ROW_CLOCKS);
  endfunction : clks_to_rows

  state_type                  state_q, state_d;
  logic [11:0]                rowClk_q;
  logic [31:0]                rowCnt_q;
  logic [31:0]                framesDone_q;
  logic [31:0]                pendExp_q;
  logic                       pendValid_q;
  logic                       longClass_q;
  logic                       firstEdge_q;
  logic                       trigPrev_q;
  logic [31:0]                pulseLen_q;
  logic [31:0]                cycleRows_q;
  logic [7:0]                 frameSeq_q;
  logic [7:0]                 mem [0:`MEM_DEPTH-1];
  logic [`MEM_PTR_W:0]        wrPtr_q, rdPtr_q;

  wire isOverlap  = (trigMode == TRIG_INT_OVL) || (trigMode == TRIG_EXT_OVL) ||
                    (trigMode == TRIG_EXPO_OVL) || (trigMode == TRIG_START_OVL);
  wire isExtEdge  = (trigMode == TRIG_EXT) || (trigMode == TRIG_EXT_OVL);
  wire isExpo     = (trigMode == TRIG_EXPO) || (trigMode == TRIG_EXPO_OVL);
  wire isStart    = (trigMode == TRIG_START) || (trigMode == TRIG_START_OVL);
  wire [31:0] frameRows = (windowRows == 16'd0) ? 32'(`FULL_FRAME_ROWS)
                                                : 32'(windowRows);
  wire [31:0] gapRows   = 32'(interFrameRows);
  wire [31:0] reqRows   = clks_to_rows(exposureClks);
  wire        reqLong   = reqRows >= frameRows + `LONG_MIN_ROWS;
  wire [31:0] ovlMin    = frameRows + gapRows + 32'd1;
  wire [31:0] longMin   = frameRows + `LONG_MIN_ROWS;
  wire [31:0] shortMax  = frameRows + `SHORT_TOP_ROWS;
  wire [31:0] expoMin   = frameRows + `SHORT_TOP_ROWS;
  wire [31:0] expoOvlMin = 32'd2 * (frameRows + gapRows);
  // Legal range for the active mode and locked class
  wire [31:0] modeMin   = isOverlap ? ovlMin :
                          (isExtEdge || longClass_q) ? longMin : 32'd1;
  wire [31:0] modeMax   = (!isOverlap && !isExtEdge && !longClass_q) ? shortMax
                                                                     : 32'hffffffff;
  wire [31:0] clampRows = (reqRows < modeMin) ? modeMin :
                          (reqRows > modeMax) ? modeMax : reqRows;
  wire        rowTick   = (rowClk_q == `ROW_CLOCKS - 12'd1);
  wire        trigIn    = extTrigger | hostTrigger;
  wire        rise      = trigIn & ~trigPrev_q;
  wire        fall      = ~trigIn & trigPrev_q;
  wire        pulseOk   = pulseLen_q + 32'd1 >= `MIN_PULSE_CLKS;
  wire        intOnly   = (trigMode == TRIG_INT) || (trigMode == TRIG_INT_OVL);
  wire        intTimed  = intOnly || (isStart && !firstEdge_q);
  wire [`MEM_PTR_W:0] used = wrPtr_q - rdPtr_q;
  wire        full      = used == (`MEM_PTR_W+1)'(`MEM_DEPTH);
  wire        empty     = used == '0;
  wire        seriesDone = (acqMode == ACQ_SINGLE && framesDone_q != 32'd0) ||
                           (acqMode == ACQ_SERIES && framesDone_q >= frameCount);
  wire        accept    = (state_q == S_ARMED) && rise && !full;
  wire        expoEnd   = trigMode == TRIG_EXPO ? (fall && rowCnt_q >= expoMin)
                        : trigMode == TRIG_EXPO_OVL ? (rise && rowCnt_q >= expoOvlMin)
                        : (rowTick && rowCnt_q + 32'd1 >= exposureRows_q);
  wire        readEnd   = rowTick && rowCnt_q + 32'd1 >= frameRows;
  wire        cycleEnd  = rowTick && rowCnt_q + 32'd1 >= cycleRows_q;
  // Discard the frame of the first overlap external-exposure edge
  wire        keepFrame = !(trigMode == TRIG_EXPO_OVL && firstEdge_q);
  wire        storeFrame = (state_q == S_READ) && readEnd && keepFrame;
  wire        overflow  = storeFrame && full && acqMode == ACQ_CONT;
  wire        sendFrame = !empty && txReady && !frameValid;
  wire        stop      = acqAbort || overflow;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:   if (acqStart) state_d = intOnly ? S_EXPOSE : S_ARMED;
      S_ARMED:  if (accept) state_d = S_EXPOSE;
      S_EXPOSE: if (expoEnd) state_d = S_READ;
      S_READ:   if (readEnd) state_d = S_WAIT;
      S_WAIT:
        if (seriesDone) state_d = S_IDLE;
        else if (!intTimed || isExpo) state_d = S_ARMED;
        else if (isOverlap || cycleEnd) state_d = S_EXPOSE;
    endcase
    if (stop) state_d = S_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      rowClk_q <= 12'd0;
      rowCnt_q <= 32'd0;
      trigPrev_q <= 1'b0;
      pulseLen_q <= 32'd0;
    end
    else
    begin
      state_q <= state_d;
      rowClk_q <= (rowTick || state_q != state_d) ? 12'd0 : rowClk_q + 12'd1;
      rowCnt_q <= (state_q != state_d) ? 32'd0 : rowCnt_q + 32'(rowTick);
      trigPrev_q <= trigIn;
      pulseLen_q <= trigIn ? pulseLen_q + 32'd1 : 32'd0;
    end
  end

  // Strobes shared by the register blocks below
  wire        startNow  = (state_q == S_IDLE) && acqStart;
  wire        expWrTake = exposureWr && (state_q != S_IDLE) && !isExpo;
  wire        expoDone  = (state_q == S_EXPOSE) && expoEnd;
  wire        stored    = storeFrame && !full;
  wire [31:0] startRows = (reqRows == 32'd0) ? 32'd1 : reqRows;

  // Class and rate are latched at start only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      longClass_q <= 1'b0;
      cycleRows_q <= 32'd0;
    end
    else if (startNow)
    begin
      longClass_q <= reqLong;
      cycleRows_q <= cyclePeriodRows;
    end
  end

  // Active exposure changes only between frames
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exposureRows_q <= 32'd1;
    end
    else if (startNow)
    begin
      exposureRows_q <= startRows;
    end
    else if (expoDone && pendValid_q)
    begin
      exposureRows_q <= pendExp_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pendExp_q <= 32'd1;
    end
    else if (expWrTake)
    begin
      pendExp_q <= clampRows;
    end
  end

  // A write in the cycle the exposure ends stays pending
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pendValid_q <= 1'b0;
    end
    else if (startNow)
    begin
      pendValid_q <= 1'b0;
    end
    else if (expWrTake)
    begin
      pendValid_q <= 1'b1;
    end
    else if (expoDone)
    begin
      pendValid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      firstEdge_q <= 1'b1;
    end
    else if (startNow)
    begin
      firstEdge_q <= 1'b1;
    end
    else if ((accept && pulseOk) || (state_q == S_READ && readEnd))
    begin
      firstEdge_q <= 1'b0;
    end
  end

  // Frame memory, written in production order, drained in the same order
  always_ff @(posedge clk)
  begin
    if (stored) mem[wrPtr_q[`MEM_PTR_W-1:0]] <= frameSeq_q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= '0;
      frameSeq_q <= 8'h00;
    end
    else if (stored)
    begin
      wrPtr_q <= wrPtr_q + (`MEM_PTR_W+1)'(1);
      frameSeq_q <= frameSeq_q + 8'h01;
    end
  end

  // Frame count restarts with every acquisition
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      framesDone_q <= 32'd0;
    end
    else if (startNow)
    begin
      framesDone_q <= 32'd0;
    end
    else if (stored)
    begin
      framesDone_q <= framesDone_q + 32'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdPtr_q <= '0;
      frameValid <= 1'b0;
      frameId <= 8'h00;
    end
    else
    begin
      frameValid <= sendFrame;
      if (sendFrame)
      begin
        frameId <= mem[rdPtr_q[`MEM_PTR_W-1:0]];
        rdPtr_q <= rdPtr_q + (`MEM_PTR_W+1)'(1);
      end
    end
  end

  // Status levels follow the next state so they line up with it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      triggerReady <= 1'b0;
      acquiring <= 1'b0;
      exposing <= 1'b0;
    end
    else
    begin
      triggerReady <= (state_d == S_ARMED) && !full;
      acquiring <= state_d != S_IDLE;
      exposing <= state_d == S_EXPOSE;
    end
  end

  // Overflow flag holds until the next start
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memFull <= 1'b0;
      acqAborted <= 1'b0;
    end
    else
    begin
      memFull <= full;
      if (overflow)
      begin
        acqAborted <= 1'b1;
      end
      else if (acqStart)
      begin
        acqAborted <= 1'b0;
      end
    end
  end
endmodule : camera_acquisition_sequencer

// File: test/cam_host_model.sv
// Far-side model: trigger source and host frame grabber
`timescale 1ns/100ps
module cam_host_model
(
  input  wire logic clk,        // Clock
  input  wire logic rst_n,      // Reset, active low
  input  wire logic stall,      // Hold off the link
  input  wire logic fire,       // Request one trigger pulse
  input  wire logic frameValid, // Frame arrives
  output logic      txReady,    // Link can take a frame
  output logic      extTrigger, // Trigger line
  output int        frames      // Frames taken
);
  logic [1:0] pulse_q;
  assign txReady = !stall;
  // Two-clock pulse per request
  assign extTrigger = |pulse_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      pulse_q <= 2'h0;
    else
      pulse_q <= {pulse_q[0], fire};
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      frames <= 0;
    else if (frameValid)
      frames <= frames + 1;
endmodule : cam_host_model

// File: test/cam_seq_properties.sv
// Port assertions for the acquisition sequencer
`timescale 1ns/100ps
module cam_seq_checker
  import cam_seq_pkg::*;
(
  input wire logic                       clk,            // Clock
  input wire logic                       rst_n,          // Reset, active low
  input wire cam_seq_pkg::trig_mode_type trigMode,       // Trigger mode
  input wire logic                       acqStart,       // Start pulse
  input wire logic                       acqAbort,       // Abort pulse
  input wire logic                       txReady,        // Host ready
  input wire logic                       triggerReady,   // Armed
  input wire logic                       acquiring,      // Running
  input wire logic                       exposing,       // Exposing
  input wire logic                       frameValid,     // Frame out
  input wire logic [31:0]                exposureRows_q  // Active rows
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_held; exposing ##1 exposing; endsequence
  property p_pulse; frameValid |=> !frameValid; endproperty
  a_pulse: assert property (p_pulse) else $error("frame pulse too long");
  property p_txGate; frameValid |-> $past(txReady); endproperty
  a_txGate: assert property (p_txGate) else $error("frame sent to busy host");
  property p_expAcq; $rose(exposing) |-> acquiring; endproperty
  a_expAcq: assert property (p_expAcq) else $error("exposure outside run");
  property p_abort; acqAbort |-> ##[1:3] (!acquiring && !triggerReady); endproperty
  a_abort: assert property (p_abort) else $error("abort not taken");
  property p_rows; exposureRows_q != 32'h0; endproperty
  a_rows: assert property (p_rows) else $error("zero exposure rows");
  property p_held; (!trigMode[0] throughout s_held) |-> $stable(exposureRows_q); endproperty
  a_held: assert property (p_held) else $error("exposure changed mid frame");
  property p_start; (acqStart && !acquiring) |-> ##[1:3] acquiring; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_ready; triggerReady |-> acquiring; endproperty
  a_ready: assert property (p_ready) else $error("armed while idle");
endmodule : cam_seq_checker

bind camera_acquisition_sequencer cam_seq_checker checker_inst (.clk(clk), .rst_n(rst_n),
  .trigMode(trigMode), .acqStart(acqStart), .acqAbort(acqAbort), .txReady(txReady),
  .triggerReady(triggerReady), .acquiring(acquiring), .exposing(exposing),
  .frameValid(frameValid), .exposureRows_q(exposureRows_q));

// File: test/tb_camera_acquisition_sequencer.sv
// Directed bench for the acquisition sequencer
`timescale 1ns/100ps
module tb_camera_acquisition_sequencer;
  import cam_seq_pkg::*;
  logic          clk = 1'b0, rst_n = 1'b0, acqStart = 1'b0, acqAbort = 1'b0, fire = 1'b0;
  logic          exposureWr = 1'b0, stall = 1'b0, triggerReady, acquiring, exposing;
  logic          frameValid, txReady, extTrigger, memFull, acqAborted;
  logic [7:0]    frameId;
  trig_mode_type trigMode = TRIG_START;
  acq_mode_type  acqMode = ACQ_SINGLE;
  logic [31:0]   exposureClks = 32'h00000a41, exposureRows_q;
  int            frames, fail_count = 0, total_checks = 0;
  always #5 clk = ~clk;
  camera_acquisition_sequencer camera_acquisition_sequencer_inst (.clk(clk), .rst_n(rst_n),
    .trigMode(trigMode), .acqMode(acqMode), .acqStart(acqStart), .acqAbort(acqAbort),
    .windowRows(16'h0001), .interFrameRows(16'h0000), .exposureClks(exposureClks),
    .exposureWr(exposureWr), .cyclePeriodRows(32'h00000000), .frameCount(32'h00000002),
    .extTrigger(extTrigger), .hostTrigger(1'b0), .txReady(txReady), .frameId(frameId),
    .triggerReady(triggerReady), .acquiring(acquiring), .exposing(exposing),
    .frameValid(frameValid), .memFull(memFull), .acqAborted(acqAborted),
    .exposureRows_q(exposureRows_q));
  cam_host_model cam_host_model_inst (.clk(clk), .rst_n(rst_n), .stall(stall), .fire(fire),
    .frameValid(frameValid), .txReady(txReady), .extTrigger(extTrigger), .frames(frames));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    fail_count += (got !== exp);
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // Bounded wait; running out counts as a mismatch
  task automatic waitSig(ref logic s, input logic v);
    for (int n = 0; n < 40000 && s !== v; n++)
      @(posedge clk);
    check({31'h0, s}, {31'h0, v});
    if (s !== v)
      wrap_up();
  endtask : waitSig
  // One-cycle strobe: 0 start, 1 trigger, 2 abort, 3 exposure write
  task automatic hit(input int which);
    @(posedge clk);
    acqStart <= (which == 0);
    fire <= (which == 1);
    acqAbort <= (which == 2);
    exposureWr <= (which == 3);
    @(posedge clk);
    {acqStart, fire, acqAbort, exposureWr} <= 4'h0;
  endtask : hit
  initial
  begin
    repeat (3) @(posedge clk);
    check(exposureRows_q, 32'h1);
    rst_n <= 1'b1;
    hit(0);
    waitSig(triggerReady, 1'b1);
    hit(1);
    waitSig(exposing, 1'b1);
    hit(1);
    check(exposureRows_q, 32'h2);
    waitSig(frameValid, 1'b1);
    waitSig(acquiring, 1'b0);
    trigMode <= TRIG_INT;
    acqMode <= ACQ_SERIES;
    stall <= 1'b1;
    hit(0);
    waitSig(exposing, 1'b1);
    exposureClks <= 32'h00000a40;
    hit(3);
    check(exposureRows_q, 32'h2);
    waitSig(exposing, 1'b0);
    waitSig(exposing, 1'b1);
    repeat (2) @(posedge clk);
    check(exposureRows_q, 32'h1);
    waitSig(exposing, 1'b0);
    repeat (3000) @(posedge clk);
    check(32'(frames), 32'h1);
    stall <= 1'b0;
    repeat (200) @(posedge clk);
    check(32'(frames), 32'h3);
    acqMode <= ACQ_CONT;
    hit(0);
    waitSig(exposing, 1'b1);
    hit(2);
    repeat (20) @(posedge clk);
    check({28'h0, acqAborted, acquiring, triggerReady, exposing}, 32'h0);
    check(32'(frames), 32'h3);
    stall <= 1'b1;
    hit(0);
    waitSig(acqAborted, 1'b1);
    check({30'h0, memFull, acquiring}, 32'h2);
    stall <= 1'b0;
    waitSig(frameValid, 1'b1);
    check({24'h0, frameId}, 32'h3);
    wrap_up();
  end
endmodule : tb_camera_acquisition_sequencer
